//--- core/rtbc_bearing_mult.v
// bearing multiplier: spreads a fixed number of fine pulses over each coarse tooth interval
// assumes coarse_evt is a one-cycle pulse already synchronised to clk
`include "rtbc_regs.vh"
module rtbc_bearing_mult #(
  parameter             CNT_W = 24,
  parameter [5:0]       MULT  = `RTBC_FINE_PER_COARSE
) (
  input  wire           clk,
  input  wire           rst_n,
  input  wire           coarse_evt,
  output reg            fine_pulse
);
  reg [CNT_W-1:0] per_q;
  reg [CNT_W-1:0] step_q;
  reg [CNT_W-1:0] scnt_q;
  reg [5:0]       left_q;
  // the count stops one short of the tooth period, so one is added before dividing
  wire [CNT_W:0]   per_p1 = {1'b0, per_q} + {{CNT_W{1'b0}}, 1'b1};
  wire [CNT_W-1:0] step_d = {{(`RTBC_FINE_SHIFT-1){1'b0}}, per_p1[CNT_W:`RTBC_FINE_SHIFT]};

  // ****************************************************************
  // interval measurement and even spacing
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_q      <= {CNT_W{1'b0}};
      step_q     <= {CNT_W{1'b0}};
      scnt_q     <= {CNT_W{1'b0}};
      left_q     <= 6'h00;
      fine_pulse <= 1'b0;
    end else begin
      if (coarse_evt)
        per_q <= {CNT_W{1'b0}};
      else if (~&per_q)
        per_q <= per_q + 1'b1;
      if (coarse_evt) begin
        // first fine pulse rides on the tooth, the rest follow at interval/32
        step_q     <= (step_d == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1} : step_d;
        scnt_q     <= {CNT_W{1'b0}};
        left_q     <= MULT - 6'h01;
        fine_pulse <= 1'b1;
      end else if (left_q != 6'h00) begin
        if (scnt_q + 1'b1 >= step_q) begin
          scnt_q     <= {CNT_W{1'b0}};
          left_q     <= left_q - 6'h01;
          fine_pulse <= 1'b1;
        end else begin
          scnt_q     <= scnt_q + 1'b1;
          fine_pulse <= 1'b0;
        end
      end else begin
        fine_pulse <= 1'b0;
      end
    end
  end
endmodule // rtbc_bearing_mult

//--- core/rtbc_regs.vh
// register map, command and status layouts and timing constants of the trigger and bearing controller
// assumes a 250 MHz system clock; included by its bare name
`ifndef RTBC_REGS_VH
`define RTBC_REGS_VH
// ****************************************************************
// register offsets
// ****************************************************************
`define RTBC_A_CTRL       8'h00
`define RTBC_A_STATUS     8'h04
`define RTBC_A_CMD        8'h08
`define RTBC_A_INT_STAT   8'h0C
`define RTBC_A_INT_MASK   8'h10
`define RTBC_A_AZIMUTH    8'h14
// ctrl fields
`define RTBC_CTRL_STBY    0
`define RTBC_CTRL_TEST    1
`define RTBC_CTRL_RST     2'b00
// interrupt event bits
`define RTBC_EV_FAULT     0
`define RTBC_EV_CMD       1
`define RTBC_EV_FERR      2
`define RTBC_EV_ROTLOST   3
`define RTBC_EV_W         4
// ****************************************************************
// command word from the display, lsb first on the link
// ****************************************************************
`define RTBC_CMD_BITS     16
`define RTBC_CMD_TX       0
`define RTBC_CMD_PL_LO    1
`define RTBC_CMD_PL_HI    2
`define RTBC_CMD_AUTO     3
`define RTBC_CMD_SECT     4
`define RTBC_CMD_PMON     5
`define RTBC_CMD_SWATT    6
`define RTBC_CMD_TUNE_LO  8
`define RTBC_CMD_TUNE_HI  15
`define RTBC_CMD_RST      16'h0000
// ****************************************************************
// status frame to the display, msb first on the link
// ****************************************************************
`define RTBC_STAT_BITS    32
`define RTBC_ST_HM        31
`define RTBC_ST_INC       30
`define RTBC_ST_AZ_HI     29
`define RTBC_ST_AZ_LO     18
`define RTBC_ST_TXON      17
`define RTBC_ST_STBY      16
`define RTBC_ST_MODERR    15
`define RTBC_ST_ROT       14
`define RTBC_ST_BIT_HI    13
`define RTBC_ST_BIT_LO    8
`define RTBC_ST_TUNE_HI   7
`define RTBC_ST_TUNE_LO   0
// ****************************************************************
// bearing and timing
// ****************************************************************
`define RTBC_FINE_PER_COARSE 32
`define RTBC_FINE_SHIFT   5
`define RTBC_CLK_MHZ      250
`define RTBC_BIT_NS       100
`define RTBC_TRIG_NS      200
`define RTBC_PW_S_NS      100
`define RTBC_PW_M_NS      500
`define RTBC_PW_L_NS      1000
`define RTBC_PRF_S_US     333
`define RTBC_PRF_M_US     1000
`define RTBC_PRF_L_US     1667
`define RTBC_ROT_TMO_MS   100
`define RTBC_FAULT_LIMIT  8
`define RTBC_NS2CYC(ns)   (((ns) * `RTBC_CLK_MHZ + 999) / 1000)
`endif

//--- core/rtbc_top.v
// trigger and bearing controller of a radar transceiver
// assumes one 250 MHz clock; all input pins except clk, rst_n and the register port are asynchronous and are synchronised here
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`include "rtbc_regs.vh"
module rtbc_top #(
  parameter [31:0]   PRF_S_CYC   = `RTBC_PRF_S_US * `RTBC_CLK_MHZ,
  parameter [31:0]   PRF_M_CYC   = `RTBC_PRF_M_US * `RTBC_CLK_MHZ,
  parameter [31:0]   PRF_L_CYC   = `RTBC_PRF_L_US * `RTBC_CLK_MHZ,
  parameter [31:0]   ROT_TMO_CYC = `RTBC_ROT_TMO_MS * 1000 * `RTBC_CLK_MHZ,
  parameter [15:0]   BIT_CYC     = `RTBC_NS2CYC(`RTBC_BIT_NS),
  parameter          TUNE_W      = 8
) (
  input  wire               clk,
  input  wire               rst_n,
  input  wire [7:0]         addr,
  input  wire [31:0]        wdata,
  input  wire               wr,
  input  wire               rd,
  output reg  [31:0]        rdata,
  input  wire               cmd_rx,
  output reg                status_tx,
  input  wire               coarse_in,
  input  wire               heading_in,
  input  wire               mod_fault,
  input  wire [TUNE_W-1:0]  tune_level,
  output reg                trigger_out,
  output reg                mod_fire,
  output reg                contactor_on,
  output reg                tx_enabled,
  output reg                swept_att_en,
  output reg                auto_tune_sel,
  output reg  [7:0]         tune_value,
  output reg                sector_blank,
  output reg                perf_mon_on,
  output wire               fine_pulse,
  output reg                irq
);
  localparam [15:0] TRIG_CYC = `RTBC_NS2CYC(`RTBC_TRIG_NS);
  localparam [15:0] PW_S_CYC = `RTBC_NS2CYC(`RTBC_PW_S_NS);
  localparam [15:0] PW_M_CYC = `RTBC_NS2CYC(`RTBC_PW_M_NS);
  localparam [15:0] PW_L_CYC = `RTBC_NS2CYC(`RTBC_PW_L_NS);
  localparam [3:0]  FLIMIT   = `RTBC_FAULT_LIMIT;
  localparam [1:0]  S_IDLE = 2'd0, S_START = 2'd1, S_DATA = 2'd2, S_STOP = 2'd3;

  // picks one of three settings by pulse length code; code 3 acts as long
  function [31:0] by_len;
    input [1:0]  len;
    input [31:0] s;
    input [31:0] m;
    input [31:0] l;
    begin
      case (len)
        2'b00:   by_len = s;
        2'b01:   by_len = m;
        default: by_len = l;
      endcase
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [1:0] rx_s_q, co_s_q, hm_s_q, mf_s_q;
  reg       co_d_q, hm_d_q;
  reg [TUNE_W-1:0] tl_a_q, tl_b_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s_q <= 2'b11;
      co_s_q <= 2'b00;
      hm_s_q <= 2'b00;
      mf_s_q <= 2'b00;
      co_d_q <= 1'b0;
      hm_d_q <= 1'b0;
      tl_a_q <= {TUNE_W{1'b0}};
      tl_b_q <= {TUNE_W{1'b0}};
    end else begin
      rx_s_q <= {rx_s_q[0], cmd_rx};
      co_s_q <= {co_s_q[0], coarse_in};
      hm_s_q <= {hm_s_q[0], heading_in};
      mf_s_q <= {mf_s_q[0], mod_fault};
      co_d_q <= co_s_q[1];
      hm_d_q <= hm_s_q[1];
      tl_a_q <= tune_level;
      tl_b_q <= tl_a_q;
    end
  end
  wire coarse_evt = co_s_q[1] & ~co_d_q;
  wire hm_evt     = hm_s_q[1] & ~hm_d_q;
  wire fault_lvl  = mf_s_q[1];

  rtbc_bearing_mult #(
    .CNT_W      (24)
  ) u_mult (
    .clk        (clk),
    .rst_n      (rst_n),
    .coarse_evt (coarse_evt),
    .fine_pulse (fine_pulse)
  );

  // ****************************************************************
  // command receiver: start, 16 data bits lsb first, stop
  // ****************************************************************
  reg [1:0]  rx_st_q;
  reg [15:0] rx_cnt_q;
  reg [4:0]  rx_bit_q;
  reg [15:0] rx_sh_q;
  reg [15:0] cmd_q;
  reg        cmd_ev_q, ferr_ev_q;
  wire       rx_b = rx_s_q[1];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q   <= S_IDLE;
      rx_cnt_q  <= 16'h0000;
      rx_bit_q  <= 5'h00;
      rx_sh_q   <= 16'h0000;
      cmd_q     <= `RTBC_CMD_RST;
      cmd_ev_q  <= 1'b0;
      ferr_ev_q <= 1'b0;
    end else begin
      cmd_ev_q  <= 1'b0;
      ferr_ev_q <= 1'b0;
      case (rx_st_q)
        S_IDLE: begin
          rx_cnt_q <= {1'b0, BIT_CYC[15:1]};
          if (!rx_b)
            rx_st_q <= S_START;
        end
        S_START: begin
          if (rx_cnt_q == 16'h0000) begin
            rx_cnt_q <= BIT_CYC - 16'h0001;
            rx_bit_q <= 5'h00;
            rx_st_q  <= rx_b ? S_IDLE : S_DATA;
          end else
            rx_cnt_q <= rx_cnt_q - 16'h0001;
        end
        S_DATA: begin
          if (rx_cnt_q == 16'h0000) begin
            rx_cnt_q <= BIT_CYC - 16'h0001;
            rx_sh_q  <= {rx_b, rx_sh_q[15:1]};
            rx_bit_q <= rx_bit_q + 5'h01;
            if (rx_bit_q == `RTBC_CMD_BITS - 1)
              rx_st_q <= S_STOP;
          end else
            rx_cnt_q <= rx_cnt_q - 16'h0001;
        end
        S_STOP: begin
          if (rx_cnt_q == 16'h0000) begin
            rx_st_q <= S_IDLE;
            if (rx_b) begin
              cmd_q    <= rx_sh_q;
              cmd_ev_q <= 1'b1;
            end else
              ferr_ev_q <= 1'b1;
          end else
            rx_cnt_q <= rx_cnt_q - 16'h0001;
        end
        default: rx_st_q <= S_IDLE;
      endcase
    end
  end
  wire [1:0] plen = cmd_q[`RTBC_CMD_PL_HI:`RTBC_CMD_PL_LO];

  // ****************************************************************
  // rotation watch, fault shutdown and interlocks
  // ****************************************************************
  reg [1:0]  ctrl_q;
  reg [31:0] rot_tmr_q;
  reg        rot_q, fault_q, fire_flt_q;
  reg [3:0]  fcnt_q;
  wire       fire_end;
  wire       stby_req = ~cmd_q[`RTBC_CMD_TX] | ctrl_q[`RTBC_CTRL_STBY];
  wire       tx_ok = ~stby_req & ~fault_q & (rot_q | ctrl_q[`RTBC_CTRL_TEST]);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // no tooth seen yet: start out as not rotating
      rot_tmr_q    <= ROT_TMO_CYC;
      rot_q        <= 1'b0;
      fault_q      <= 1'b0;
      fire_flt_q   <= 1'b0;
      fcnt_q       <= 4'h0;
      contactor_on <= 1'b0;
      tx_enabled   <= 1'b0;
    end else begin
      if (coarse_evt)
        rot_tmr_q <= 32'h0000_0000;
      else if (rot_tmr_q < ROT_TMO_CYC)
        rot_tmr_q <= rot_tmr_q + 32'h0000_0001;
      rot_q <= coarse_evt | (rot_tmr_q < ROT_TMO_CYC);
      if (mod_fire & fault_lvl)
        fire_flt_q <= 1'b1;
      else if (fire_end)
        fire_flt_q <= 1'b0;
      // consecutive faulty firings up to the limit latch the shutdown
      if (fire_end)
        fcnt_q <= (fire_flt_q | fault_lvl) ? ((fcnt_q == FLIMIT) ? fcnt_q : fcnt_q + 4'h1) : 4'h0;
      if (fire_end & (fire_flt_q | fault_lvl) & (fcnt_q == FLIMIT - 4'h1))
        fault_q <= 1'b1;
      else if (cmd_ev_q & ~cmd_q[`RTBC_CMD_TX])
        fault_q <= 1'b0;
      contactor_on <= ~stby_req & ~fault_q;
      tx_enabled   <= tx_ok;
    end
  end

  // ****************************************************************
  // repetition rate, trigger and modulator pulse
  // ****************************************************************
  reg [31:0] prf_q;
  reg [15:0] trg_q, pw_q;
  wire [31:0] prf_per = by_len(plen, PRF_S_CYC, PRF_M_CYC, PRF_L_CYC);
  wire [31:0] pw_sel  = by_len(plen, {16'h0000, PW_S_CYC}, {16'h0000, PW_M_CYC}, {16'h0000, PW_L_CYC});
  assign fire_end = mod_fire & (pw_q == 16'h0001);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prf_q       <= 32'h0000_0000;
      trg_q       <= 16'h0000;
      pw_q        <= 16'h0000;
      trigger_out <= 1'b0;
      mod_fire    <= 1'b0;
    end else begin
      prf_q <= (prf_q + 32'h0000_0001 >= prf_per) ? 32'h0000_0000 : prf_q + 32'h0000_0001;
      if ((prf_q == 32'h0000_0000) & tx_ok) begin
        trg_q       <= TRIG_CYC;
        pw_q        <= pw_sel[15:0];
        trigger_out <= 1'b1;
        mod_fire    <= 1'b1;
      end else begin
        if (trg_q > 16'h0001)
          trg_q <= trg_q - 16'h0001;
        else begin
          trg_q       <= 16'h0000;
          trigger_out <= 1'b0;
        end
        if (pw_q > 16'h0001)
          pw_q <= pw_q - 16'h0001;
        else begin
          pw_q     <= 16'h0000;
          mod_fire <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // decoded control outputs
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swept_att_en  <= 1'b0;
      auto_tune_sel <= 1'b0;
      tune_value    <= 8'h00;
      sector_blank  <= 1'b0;
      perf_mon_on   <= 1'b0;
    end else begin
      swept_att_en  <= cmd_q[`RTBC_CMD_SWATT];
      auto_tune_sel <= cmd_q[`RTBC_CMD_AUTO];
      tune_value    <= cmd_q[`RTBC_CMD_TUNE_HI:`RTBC_CMD_TUNE_LO];
      sector_blank  <= cmd_q[`RTBC_CMD_SECT];
      perf_mon_on   <= cmd_q[`RTBC_CMD_PMON];
    end
  end

  // ****************************************************************
  // azimuth count and status transmitter: start, 32 bits msb first, stop
  // ****************************************************************
  reg [11:0] az_q;
  reg        hm_seen_q, pend_q;
  reg [1:0]  tx_st_q;
  reg [15:0] tx_cnt_q;
  reg [5:0]  tx_bit_q;
  reg [31:0] tx_sh_q;
  wire       tuned = (tl_b_q == {TUNE_W{1'b0}});
  wire [5:0] built_in_test_report = {1'b0, tuned, ferr_ev_q, ~rot_q, fire_flt_q, fault_q};
  wire       load = pend_q & (tx_st_q == S_IDLE);
  wire [31:0] frame = {hm_seen_q, 1'b1, az_q, tx_enabled, stby_req, fault_q, rot_q, built_in_test_report, tl_b_q[TUNE_W-1 -: 8]};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      az_q      <= 12'h000;
      hm_seen_q <= 1'b0;
      pend_q    <= 1'b0;
      tx_st_q   <= S_IDLE;
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 6'h00;
      tx_sh_q   <= 32'h0000_0000;
      status_tx <= 1'b1;
    end else begin
      if (hm_evt)
        az_q <= 12'h000;
      else if (fine_pulse)
        az_q <= az_q + 12'h001;
      // marker flag set wins over the clear at frame load
      if (hm_evt)
        hm_seen_q <= 1'b1;
      else if (load)
        hm_seen_q <= 1'b0;
      // a frame is requested by every fine bearing pulse
      if (fine_pulse)
        pend_q <= 1'b1;
      else if (load)
        pend_q <= 1'b0;
      case (tx_st_q)
        S_IDLE: begin
          status_tx <= 1'b1;
          if (load) begin
            tx_sh_q   <= frame;
            tx_cnt_q  <= BIT_CYC - 16'h0001;
            status_tx <= 1'b0;
            tx_st_q   <= S_START;
          end
        end
        S_START, S_DATA: begin
          if (tx_cnt_q == 16'h0000) begin
            tx_cnt_q  <= BIT_CYC - 16'h0001;
            status_tx <= tx_sh_q[31];
            tx_sh_q   <= {tx_sh_q[30:0], 1'b0};
            tx_bit_q  <= (tx_st_q == S_START) ? 6'h01 : tx_bit_q + 6'h01;
            if ((tx_st_q == S_DATA) & (tx_bit_q == `RTBC_STAT_BITS)) begin
              status_tx <= 1'b1;
              tx_st_q   <= S_STOP;
            end else
              tx_st_q <= S_DATA;
          end else
            tx_cnt_q <= tx_cnt_q - 16'h0001;
        end
        S_STOP: begin
          if (tx_cnt_q == 16'h0000)
            tx_st_q <= S_IDLE;
          else
            tx_cnt_q <= tx_cnt_q - 16'h0001;
        end
        default: tx_st_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // register port and interrupt
  // ****************************************************************
  reg [3:0] ist_q, imask_q;
  reg       fault_d1_q, rot_d1_q;
  wire [3:0] ev;
  assign ev[`RTBC_EV_FAULT]   = fault_q & ~fault_d1_q;
  assign ev[`RTBC_EV_CMD]     = cmd_ev_q;
  assign ev[`RTBC_EV_FERR]    = ferr_ev_q;
  assign ev[`RTBC_EV_ROTLOST] = rot_d1_q & ~rot_q & contactor_on;
  wire [3:0] w1c = (wr & (addr == `RTBC_A_INT_STAT)) ? wdata[3:0] : 4'h0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= `RTBC_CTRL_RST;
      ist_q      <= 4'h0;
      imask_q    <= 4'h0;
      fault_d1_q <= 1'b0;
      rot_d1_q   <= 1'b0;
      irq        <= 1'b0;
      rdata      <= 32'h0000_0000;
    end else begin
      fault_d1_q <= fault_q;
      rot_d1_q   <= rot_q;
      if (wr & (addr == `RTBC_A_CTRL))
        ctrl_q <= wdata[1:0];
      if (wr & (addr == `RTBC_A_INT_MASK))
        imask_q <= wdata[3:0];
      ist_q <= (ist_q & ~w1c) | ev;
      irq   <= |(ist_q & imask_q);
      rdata <= 32'h0000_0000;
      if (rd) begin
        case (addr)
          `RTBC_A_CTRL:     rdata <= {30'h0, ctrl_q};
          `RTBC_A_STATUS:   rdata <= {14'h0000, built_in_test_report, rot_q, fault_q, tx_enabled, contactor_on, tl_b_q[TUNE_W-1 -: 8]};
          `RTBC_A_CMD:      rdata <= {16'h0, cmd_q};
          `RTBC_A_INT_STAT: rdata <= {28'h0, ist_q};
          `RTBC_A_INT_MASK: rdata <= {28'h0, imask_q};
          `RTBC_A_AZIMUTH:  rdata <= {20'h0, az_q};
          default:          rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // rtbc_top

//--- verification/rtbc_display_model.sv
// display unit model: sends command frames, collects status frames
// assumes idle-high one-way links timed off clk, BIT_CYC cycles a bit
module rtbc_display_model #(
  parameter int BIT_CYC = 4
) (
  input  wire logic clk,
  output logic      cmd_rx,
  input  wire logic status_tx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] fr;
  logic [31:0] frame_q[$];
  logic        alarm = 1'b0;
  initial cmd_rx = 1'b1;
  // command frame: start, 16 bits lsb first, stop, on its own line
  task automatic send_cmd(input logic [15:0] c);
    @(posedge clk);
    cmd_rx <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      cmd_rx <= (i < 16) ? c[i] : 1'b1;
    end
    repeat (2 * BIT_CYC) @(posedge clk);
  endtask
  // status frame receiver, sampled mid-bit, msb first
  initial forever begin
    @(negedge status_tx);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 31; i >= 0; i--) begin
      repeat (BIT_CYC) @(posedge clk);
      fr[i] = status_tx;
    end
    repeat (BIT_CYC) @(posedge clk);
    frame_q.push_back(fr);
    if (fr[15] === 1'b1 && !alarm) begin
      alarm = 1'b1;
      send_cmd(16'h0000);
    end
  end
endmodule // rtbc_display_model

//--- verification/rtbc_top_properties.sv
// port checks of the trigger and bearing controller
// assumes binding into rtbc_top, one clock clk and reset rst_n
module rtbc_top_properties (
  input wire        clk,
  input wire        rst_n,
  input wire        rd,
  input wire [31:0] rdata,
  input wire        coarse_in,
  input wire        status_tx,
  input wire        trigger_out,
  input wire        mod_fire,
  input wire        contactor_on,
  input wire        tx_enabled,
  input wire        fine_pulse
);
  logic [7:0] tcnt_q;
  logic [7:0] tcnt_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // length of the current trigger pulse
  assign tcnt_d = trigger_out ? tcnt_q + 8'h01 : 8'h00;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) tcnt_q <= 8'h00;
    else tcnt_q <= tcnt_d;
  end
  sequence s_fire;
    $rose(mod_fire);
  endsequence
  sequence s_tooth;
    $rose(coarse_in);
  endsequence
  a_fire_needs_tx: assert property (s_fire |-> tx_enabled || $past(tx_enabled))
    else $error("firing without transmit enable");
  a_fire_min_width: assert property (s_fire |-> mod_fire [*8])
    else $error("modulator pulse too short");
  a_trig_width: assert property ($fell(trigger_out) |-> tcnt_q == 8'h32)
    else $error("trigger pulse length wrong");
  a_fire_with_trig: assert property (s_fire |-> ##[0:2] trigger_out)
    else $error("firing without trigger");
  a_fire_motor_on: assert property (s_fire |-> contactor_on || $past(contactor_on))
    else $error("firing with motor stopped");
  a_tooth_gives_fine: assert property (s_tooth |-> ##[2:8] fine_pulse)
    else $error("no fine pulse after tooth");
  a_fine_one_cycle: assert property (fine_pulse |=> !fine_pulse)
    else $error("fine pulses not spread");
  a_status_start_bit: assert property ($fell(status_tx) |-> !status_tx [*4])
    else $error("status bit shorter than a bit time");
  a_read_data_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule // rtbc_top_properties

bind rtbc_top rtbc_top_properties chk_i (.clk(clk), .rst_n(rst_n), .rd(rd), .rdata(rdata), .coarse_in(coarse_in),
  .status_tx(status_tx), .trigger_out(trigger_out), .mod_fire(mod_fire), .contactor_on(contactor_on),
  .tx_enabled(tx_enabled), .fine_pulse(fine_pulse));

//--- verification/rtbc_top_test.sv
// self-checking bench of the trigger and bearing controller
// assumes rtbc_top and the display model; long counts shortened by parameter
module rtbc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CP = 6400;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, coarse_in = 1'b0, heading_in = 1'b0;
  logic        mod_fault = 1'b0, status_tx, cmd_rx, trigger_out, mod_fire, contactor_on, tx_enabled, irq;
  logic        swept_att_en, auto_tune_sel, sector_blank, perf_mon_on, fine_pulse;
  logic [7:0]  addr = 8'h00, tune_level = 8'h00, tune_value;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [15:0] cmd;
  int          err_count = 0, tests_run = 0, fine_n, gap_lo, gap_hi, last_f, cyc = 0, w, p, fw, fp, rot_on = 0;
  int          pw[4] = '{25, 125, 250, 250}, prf[4] = '{400, 600, 800, 800};
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  rtbc_top #(.PRF_S_CYC(32'h190), .PRF_M_CYC(32'h258), .PRF_L_CYC(32'h320), .ROT_TMO_CYC(32'h1F40),
    .BIT_CYC(16'h0004)) uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cmd_rx(cmd_rx), .status_tx(status_tx), .coarse_in(coarse_in), .heading_in(heading_in),
    .mod_fault(mod_fault), .tune_level(tune_level), .trigger_out(trigger_out), .mod_fire(mod_fire),
    .contactor_on(contactor_on), .tx_enabled(tx_enabled), .swept_att_en(swept_att_en),
    .auto_tune_sel(auto_tune_sel), .tune_value(tune_value), .sector_blank(sector_blank),
    .perf_mon_on(perf_mon_on), .fine_pulse(fine_pulse), .irq(irq));
  rtbc_display_model disp (.clk(clk), .cmd_rx(cmd_rx), .status_tx(status_tx));
  // ****************************************************************
  // antenna teeth and fine pulse spacing monitor
  // ****************************************************************
  always begin
    @(posedge clk);
    if (rot_on) begin
      coarse_in <= 1'b1;
      repeat (20) @(posedge clk);
      coarse_in <= 1'b0;
      repeat (CP - 21) @(posedge clk);
    end
  end
  always @(posedge clk) if (fine_pulse === 1'b1) begin
    fine_n++;
    if (last_f > 0 && cyc - last_f < gap_lo) gap_lo = cyc - last_f;
    if (last_f > 0 && cyc - last_f > gap_hi) gap_hi = cyc - last_f;
    last_f = cyc;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // a wait that used up its bound counts as a mismatch and ends the run
  task automatic lim(input int n, input int m);
    if (n >= m) begin
      err_count++;
      final_report();
    end
  endtask
  // runs to the next rise of the modulator pulse, measuring width and period
  task automatic wait_fire();
    fw = 0;
    fp = 0;
    while (mod_fire === 1'b1 && fp < 2000) begin @(negedge clk); fp++; fw++; end
    while (mod_fire !== 1'b1 && fp < 2000) begin @(negedge clk); fp++; end
    if (fp >= 2000) begin err_count++; final_report(); end
  endtask
  initial begin
    rv = $urandom(15);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rreg(8'h00); chk("ctrl reset", 32'h0, rv);
    rreg(8'h10); chk("mask reset", 32'h0, rv);
    rreg(8'h18); chk("unmapped", 32'h0, rv);
    wreg(8'h10, 32'h2);
    cmd = 16'($urandom);
    cmd[2:0] = 3'b001;
    disp.send_cmd(cmd);
    repeat (8) @(negedge clk);
    chk("swept att", cmd[6], swept_att_en);
    chk("tune select", cmd[3], auto_tune_sel);
    chk("blanking", {cmd[5:4], cmd[15:8]}, {perf_mon_on, sector_blank, tune_value});
    chk("motor on", 1, contactor_on);
    chk("tx not rotating", 0, tx_enabled);
    chk("irq raised", 1, irq);
    rreg(8'h08); chk("cmd reg", cmd, rv);
    wreg(8'h10, 32'h0); repeat (3) @(negedge clk); chk("irq masked", 0, irq);
    wreg(8'h0C, 32'h2); wreg(8'h10, 32'h2); repeat (3) @(negedge clk); chk("irq cleared", 0, irq);
    rot_on = 1;
    tune_level <= 8'($urandom) | 8'h01;
    repeat (2 * CP) @(posedge clk);
    for (w = 0; w < CP && coarse_in !== 1'b1; w++) @(posedge clk);
    lim(w, CP);
    repeat (50) @(posedge clk);
    fine_n = 0; last_f = 0; gap_lo = CP; gap_hi = 0;
    disp.frame_q.delete();
    repeat (CP) @(posedge clk);
    chk("fine per tooth", 32, fine_n);
    chk("even spacing", 1, gap_lo >= CP / 32 - 1 && gap_hi <= CP / 32 + 1);
    chk("frame per pulse", 1, disp.frame_q.size() >= 31);
    for (w = 1; w < disp.frame_q.size(); w++) begin
      chk("azimuth step", disp.frame_q[w - 1][29:18] + 12'h001, disp.frame_q[w][29:18]);
      chk("tune report", {1'b0, tune_level}, {disp.frame_q[w][12], disp.frame_q[w][7:0]});
      chk("status bits", 3'b111, {disp.frame_q[w][30], disp.frame_q[w][17], disp.frame_q[w][14]});
    end
    chk("tx rotating", 1, tx_enabled);
    rreg(8'h04); chk("status reg", {24'h00000B, tune_level}, rv);
    tune_level <= 8'h00;
    heading_in <= 1'b1;
    repeat (20) @(posedge clk);
    heading_in <= 1'b0;
    w = disp.frame_q.size();
    for (p = 0; p < 2000 && disp.frame_q.size() < w + 2; p++) @(posedge clk);
    lim(p, 2000);
    chk("marker", 1, disp.frame_q[w][31] | disp.frame_q[w + 1][31]);
    chk("tuned", 1, disp.frame_q[w + 1][12]);
    for (p = 0; p < 4; p++) begin
      cmd[2:1] = p[1:0];
      disp.send_cmd(cmd);
      wait_fire();
      wait_fire();
      wait_fire();
      chk("pulse width", pw[p], fw);
      chk("prf period", prf[p], fp);
    end
    rot_on = 0;
    repeat (8000 + CP) @(posedge clk);
    chk("tx stopped", 0, tx_enabled);
    wreg(8'h00, 32'h2); repeat (4) @(negedge clk); chk("tx test mode", 1, tx_enabled);
    wreg(8'h00, 32'h3); repeat (4) @(negedge clk); chk("motor standby", 0, contactor_on);
    wreg(8'h00, 32'h2);
    rot_on = 1;
    mod_fault <= 1'b1;
    for (w = 0; w < 20000 && contactor_on !== 1'b0; w++) @(negedge clk);
    lim(w, 20000);
    chk("fault stops motor", 0, contactor_on);
    for (w = 0; w < 20000 && disp.alarm !== 1'b1; w++) @(negedge clk);
    lim(w, 20000);
    chk("error sent", 1, disp.alarm);
    @(posedge clk);
    mod_fault <= 1'b0;
    rreg(8'h0C); chk("fault event", 1, rv[0]);
    final_report();
  end
endmodule // rtbc_top_test
